// *** rtl/asc_pkg.sv ***
// Package with register map, field positions and timing for the ADC sequencer
package asc_pkg;
   localparam int           DATA_W          = 8;
   localparam int           CODE_W          = 10;
   localparam int           NUM_CHAN        = 10;
   localparam int           CHAN_W          = 4;
   localparam int           AVG_COUNT       = 16;
   localparam int           AVG_SHIFT       = 4;
   localparam int           ACC_W           = CODE_W + AVG_SHIFT;
   // Register offsets
   localparam logic [7:0]   OFS_CFG_SIX     = 8'h10;
   localparam logic [7:0]   OFS_EXT_A       = 8'h1F;
   localparam logic [7:0]   OFS_EXT_B       = 8'h76;
   localparam logic [7:0]   OFS_EXT_C       = 8'h77;
   localparam logic [7:0]   OFS_TACH_SEL    = 8'h55;
   localparam logic [7:0]   OFS_CFG_TWO     = 8'h73;
   localparam logic [7:0]   OFS_GLOBAL_ATTENUATOR_BYPASS_CFG    = 8'h7D;
   localparam logic [7:0]   OFS_VAL_CURR    = 8'h1D;
   localparam logic [7:0]   OFS_VAL_TERM    = 8'h1E;
   localparam logic [7:0]   OFS_VAL_V25     = 8'h20;
   localparam logic [7:0]   OFS_VAL_CORE    = 8'h21;
   localparam logic [7:0]   OFS_VAL_SUPPLY  = 8'h22;
   localparam logic [7:0]   OFS_VAL_V5      = 8'h23;
   localparam logic [7:0]   OFS_VAL_V12     = 8'h24;
   // Field positions
   localparam int           BIT_SLOW_CYCLE  = 7;
   localparam int           BIT_AVG_DIS     = 4;
   localparam int           BIT_GLOBAL_BYP  = 5;
   localparam int           BIT_SINGLE      = 6;
   localparam int           SEL_LSB         = 4;
   localparam int           BIT_BYP_V25     = 4;
   localparam int           BIT_BYP_CORE    = 5;
   localparam int           BIT_BYP_V5      = 6;
   localparam int           BIT_BYP_V12     = 7;
   // Reset values
   localparam logic [7:0]   RST_CFG_SIX     = 8'h00;
   localparam logic [7:0]   RST_TACH_SEL    = 8'h00;
   localparam logic [7:0]   RST_CFG_TWO     = 8'h00;
   localparam logic [7:0]   RST_GLOBAL_ATTENUATOR_BYPASS_CFG    = 8'h00;
   // Channel codes, in sequence order
   localparam logic [3:0]   CH_V25          = 4'h0;
   localparam logic [3:0]   CH_CORE         = 4'h1;
   localparam logic [3:0]   CH_SUPPLY       = 4'h2;
   localparam logic [3:0]   CH_V5           = 4'h3;
   localparam logic [3:0]   CH_V12          = 4'h4;
   localparam logic [3:0]   CH_REMOTE1      = 4'h5;
   localparam logic [3:0]   CH_LOCAL        = 4'h6;
   localparam logic [3:0]   CH_REMOTE2      = 4'h7;
   localparam logic [3:0]   CH_TERM         = 4'h8;
   localparam logic [3:0]   CH_CURR         = 4'h9;
   localparam logic [3:0]   CH_LAST         = 4'h9;
   // Timing
   localparam real          CLK_PERIOD_NS   = 10.0;
   localparam real          T_VOLT_MS       = 0.7;
   localparam real          T_REMOTE_MS     = 7.0;
   localparam real          T_LOCAL_MS      = 1.3;
   localparam real          T_CYCLE_MS      = 146.5;
   localparam real          T_SLOW_CYCLE_MS = 240.0;
   localparam int           VOLT_CYC   = int'(T_VOLT_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int           REMOTE_CYC =
      int'(T_REMOTE_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int           LOCAL_CYC  = int'(T_LOCAL_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int           CYCLE_CYC  = int'(T_CYCLE_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int           SLOW_CYC   =
      int'(T_SLOW_CYCLE_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int           TMR_W           = 32;
endpackage

// *** rtl/asc_result_mem.sv ***
// Small result memory: one write port, one registered read port
`timescale 1ns/1ps
module asc_result_mem #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 10,
   parameter int AW    = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] rd_data_nxt;

   always_comb begin
      rd_data_nxt = '0;
      if (32'(rd_addr) < DEPTH) begin
         rd_data_nxt = mem_r[rd_addr];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         rd_data <= rd_data_nxt;
         if (wr_en && 32'(wr_addr) < DEPTH) begin
            mem_r[wr_addr] <= wr_data;
         end
      end
   end
endmodule

// *** rtl/asc_sequencer.sv ***
// ADC round-robin sequencer with averaging, locking and attenuator control
`timescale 1ns/1ps
// Behaviour
// - Reading an extended register freezes matching value registers until they are read.
// - With averaging on in round-robin mode, sixteen conversions per channel are averaged and stored.
// - Averaging-disable bit stores single conversions instead.
// - Default round-robin cycle completes in 146.5 ms with averaging off, 323.2 ms with averaging on.
// - Unaveraged conversions take 0.7 ms voltage, 7 ms remote, 1.3 ms local.
// - Slow-cycle bit stretches the round-robin cycle to 240 ms with averaging off.
// - Global bypass bit removes attenuation from all five attenuated inputs.
// - Per-input bypass bits cover 2.5 V, core, 5 V and 12 V inputs.
// - Single-channel bit converts only the selected channel every 0.7 ms.
// - Upper nibble of the tach limit register selects the channel, codes 0-9.
// - Channel select shares storage with the tach minimum high byte.
// - Each conversion yields an unsigned 10-bit code, 0 to 1023.
// - Averaged voltage measurement is sixteen 0.7 ms conversions, about 11 ms.
module asc_sequencer #(
   parameter int VOLT_CYC   = asc_pkg::VOLT_CYC,
   parameter int REMOTE_CYC = asc_pkg::REMOTE_CYC,
   parameter int LOCAL_CYC  = asc_pkg::LOCAL_CYC,
   parameter int CYCLE_CYC  = asc_pkg::CYCLE_CYC,
   parameter int SLOW_CYC   = asc_pkg::SLOW_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic [9:0]  adc_code,
   output logic      [3:0]  adc_channel,
   output logic             adc_start,
   output logic      [4:0]  atten_bypass,
   output logic      [7:0]  tach_one_min_high,
   output logic             cycle_start
);
   typedef enum logic {ASC_SINGLE_CHANNEL_MODE, ASC_WAIT} asc_state_e;
   localparam int TW = asc_pkg::TMR_W;
   localparam int AW = asc_pkg::ACC_W;
   localparam int NC = asc_pkg::NUM_CHAN;

   // Register group
   logic [7:0]  cfg_six_r, cfg_six_nxt, tach_sel_r, tach_sel_nxt;
   logic [7:0]  cfg_two_r, cfg_two_nxt, global_attenuator_bypass_cfg_r, global_attenuator_bypass_cfg_nxt;
   logic [7:0]  rd_byte_r, rd_byte_nxt;
   logic        rd_mem_r, rd_mem_nxt;
   logic [NC-1:0] lock_r, lock_nxt;
   logic [1:0]  lsb_r [NC];
   logic [1:0]  lsb_nxt [NC];
   logic [4:0]  byp_r, byp_nxt;
   // Sequencer group
   asc_state_e  st_r, st_nxt;
   logic [3:0]  chan_r, chan_nxt;
   logic [4:0]  rep_r, rep_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt, cyc_r, cyc_nxt;
   logic [AW-1:0] acc_r, acc_nxt;
   logic        start_r, start_nxt, cstart_r, cstart_nxt;
   logic        single_q_r, single_q_nxt;
   // Memory ports
   logic        mem_we;
   logic [3:0]  mem_raddr;
   logic [9:0]  mem_wdata, mem_q;
   logic        val_hit;
   logic [3:0]  val_chan;
   logic        single, avg_dis, slow;
   logic [4:0]  rep_last;
   logic [AW-1:0] acc_sum;
   logic [9:0]  result;
   logic [TW-1:0] cyc_target;

   function automatic logic [TW-1:0] single_channel_mode_len(input logic [3:0] ch);
      logic [TW-1:0] n;
      n = TW'(VOLT_CYC);
      if (ch == asc_pkg::CH_REMOTE1 || ch == asc_pkg::CH_REMOTE2) begin
         n = TW'(REMOTE_CYC);
      end else if (ch == asc_pkg::CH_LOCAL) begin
         n = TW'(LOCAL_CYC);
      end
      return n;
   endfunction

   assign single  = cfg_two_r[asc_pkg::BIT_SINGLE];
   assign avg_dis = cfg_two_r[asc_pkg::BIT_AVG_DIS];
   assign slow    = cfg_six_r[asc_pkg::BIT_SLOW_CYCLE];

   // Value register address to channel index
   always_comb begin
      val_hit  = 1'b1;
      val_chan = asc_pkg::CH_V25;
      case (reg_addr)
         asc_pkg::OFS_VAL_V25:    val_chan = asc_pkg::CH_V25;
         asc_pkg::OFS_VAL_CORE:   val_chan = asc_pkg::CH_CORE;
         asc_pkg::OFS_VAL_SUPPLY: val_chan = asc_pkg::CH_SUPPLY;
         asc_pkg::OFS_VAL_V5:     val_chan = asc_pkg::CH_V5;
         asc_pkg::OFS_VAL_V12:    val_chan = asc_pkg::CH_V12;
         asc_pkg::OFS_VAL_TERM:   val_chan = asc_pkg::CH_TERM;
         asc_pkg::OFS_VAL_CURR:   val_chan = asc_pkg::CH_CURR;
         default:                 val_hit  = 1'b0;
      endcase
   end
   assign mem_raddr = val_chan;

   // Sequencer next state
   always_comb begin
      st_nxt       = st_r;
      chan_nxt     = chan_r;
      rep_nxt      = rep_r;
      tmr_nxt      = tmr_r;
      acc_nxt      = acc_r;
      start_nxt    = 1'b0;
      cstart_nxt   = 1'b0;
      single_q_nxt = single;
      mem_we       = 1'b0;
      rep_last     = (avg_dis || single) ? 5'h00 :
                     5'(asc_pkg::AVG_COUNT - 1);
      acc_sum      = acc_r + AW'(adc_code);
      result       = (rep_last == 5'h00) ? acc_sum[9:0] :
                     acc_sum[AW-1:asc_pkg::AVG_SHIFT];
      mem_wdata    = result;
      cyc_target   = slow ? TW'(SLOW_CYC) : TW'(CYCLE_CYC);
      cyc_nxt      = (cyc_r == {TW{1'b1}}) ? cyc_r : cyc_r + 1'b1;
      if (single != single_q_r) begin
         // Mode change restarts the sequence
         st_nxt     = ASC_SINGLE_CHANNEL_MODE;
         chan_nxt   = single ? tach_sel_r[7:asc_pkg::SEL_LSB] :
                      asc_pkg::CH_V25;
         rep_nxt    = '0;
         acc_nxt    = '0;
         tmr_nxt    = single ? TW'(VOLT_CYC) : single_channel_mode_len(asc_pkg::CH_V25);
         cyc_nxt    = '0;
         start_nxt  = 1'b1;
         cstart_nxt = !single;
      end else begin
         case (st_r)
            ASC_SINGLE_CHANNEL_MODE: begin
               tmr_nxt = tmr_r - 1'b1;
               if (tmr_r <= TW'(1)) begin
                  acc_nxt = acc_sum;
                  if (rep_r >= rep_last) begin
                     mem_we  = (chan_r <= asc_pkg::CH_LAST) &&
                               !lock_r[chan_r];
                     acc_nxt = '0;
                     rep_nxt = '0;
                     if (single) begin
                        chan_nxt  = tach_sel_r[7:asc_pkg::SEL_LSB];
                        tmr_nxt   = TW'(VOLT_CYC);
                        start_nxt = 1'b1;
                     end else if (chan_r >= asc_pkg::CH_LAST) begin
                        st_nxt = ASC_WAIT;
                     end else begin
                        chan_nxt  = chan_r + 1'b1;
                        tmr_nxt   = single_channel_mode_len(chan_r + 1'b1);
                        start_nxt = 1'b1;
                     end
                  end else begin
                     rep_nxt   = rep_r + 1'b1;
                     tmr_nxt   = single_channel_mode_len(chan_r);
                     start_nxt = 1'b1;
                  end
               end
            end
            ASC_WAIT: begin
               if (cyc_r + TW'(1) >= cyc_target) begin
                  st_nxt     = ASC_SINGLE_CHANNEL_MODE;
                  chan_nxt   = asc_pkg::CH_V25;
                  tmr_nxt    = single_channel_mode_len(asc_pkg::CH_V25);
                  cyc_nxt    = '0;
                  start_nxt  = 1'b1;
                  cstart_nxt = 1'b1;
               end
            end
            default: st_nxt = ASC_SINGLE_CHANNEL_MODE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= ASC_SINGLE_CHANNEL_MODE;
         chan_r     <= asc_pkg::CH_V25;
         rep_r      <= '0;
         tmr_r      <= TW'(VOLT_CYC);
         cyc_r      <= '0;
         acc_r      <= '0;
         start_r    <= 1'b0;
         cstart_r   <= 1'b0;
         single_q_r <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         chan_r     <= chan_nxt;
         rep_r      <= rep_nxt;
         tmr_r      <= tmr_nxt;
         cyc_r      <= cyc_nxt;
         acc_r      <= acc_nxt;
         start_r    <= start_nxt;
         cstart_r   <= cstart_nxt;
         single_q_r <= single_q_nxt;
      end
   end

   // Register file next state
   always_comb begin
      cfg_six_nxt  = cfg_six_r;
      tach_sel_nxt = tach_sel_r;
      cfg_two_nxt  = cfg_two_r;
      global_attenuator_bypass_cfg_nxt = global_attenuator_bypass_cfg_r;
      lock_nxt     = lock_r;
      lsb_nxt      = lsb_r;
      rd_byte_nxt  = rd_mem_r ? mem_q[9:2] : rd_byte_r;
      rd_mem_nxt   = 1'b0;
      if (mem_we) begin
         lsb_nxt[chan_r] = result[1:0];
      end
      if (reg_wr) begin
         case (reg_addr)
            asc_pkg::OFS_CFG_SIX:  cfg_six_nxt  = reg_wdata;
            asc_pkg::OFS_TACH_SEL: tach_sel_nxt = reg_wdata;
            asc_pkg::OFS_CFG_TWO:  cfg_two_nxt  = reg_wdata;
            asc_pkg::OFS_GLOBAL_ATTENUATOR_BYPASS_CFG: global_attenuator_bypass_cfg_nxt = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         rd_mem_nxt  = val_hit;
         rd_byte_nxt = 8'h00;
         if (val_hit) begin
            lock_nxt[val_chan] = 1'b0;
         end
         case (reg_addr)
            asc_pkg::OFS_CFG_SIX:  rd_byte_nxt = cfg_six_r;
            asc_pkg::OFS_TACH_SEL: rd_byte_nxt = tach_sel_r;
            asc_pkg::OFS_CFG_TWO:  rd_byte_nxt = cfg_two_r;
            asc_pkg::OFS_GLOBAL_ATTENUATOR_BYPASS_CFG: rd_byte_nxt = global_attenuator_bypass_cfg_r;
            asc_pkg::OFS_EXT_A: begin
               rd_byte_nxt = {4'h0, lsb_r[asc_pkg::CH_CURR],
                              lsb_r[asc_pkg::CH_TERM]};
               lock_nxt[asc_pkg::CH_TERM] = 1'b1;
               lock_nxt[asc_pkg::CH_CURR] = 1'b1;
            end
            asc_pkg::OFS_EXT_B: begin
               rd_byte_nxt = {lsb_r[asc_pkg::CH_V5], lsb_r[asc_pkg::CH_SUPPLY],
                              lsb_r[asc_pkg::CH_CORE], lsb_r[asc_pkg::CH_V25]};
               lock_nxt[asc_pkg::CH_V25]    = 1'b1;
               lock_nxt[asc_pkg::CH_CORE]   = 1'b1;
               lock_nxt[asc_pkg::CH_SUPPLY] = 1'b1;
               lock_nxt[asc_pkg::CH_V5]     = 1'b1;
            end
            asc_pkg::OFS_EXT_C: begin
               rd_byte_nxt = {6'h00, lsb_r[asc_pkg::CH_V12]};
               lock_nxt[asc_pkg::CH_V12] = 1'b1;
            end
            default: ;
         endcase
      end
      // Global bypass covers 2.5 V, core, supply, 5 V, 12 V
      byp_nxt = {5{cfg_two_r[asc_pkg::BIT_GLOBAL_BYP]}};
      byp_nxt[0] = byp_nxt[0] | global_attenuator_bypass_cfg_r[asc_pkg::BIT_BYP_V25];
      byp_nxt[1] = byp_nxt[1] | global_attenuator_bypass_cfg_r[asc_pkg::BIT_BYP_CORE];
      byp_nxt[3] = byp_nxt[3] | global_attenuator_bypass_cfg_r[asc_pkg::BIT_BYP_V5];
      byp_nxt[4] = byp_nxt[4] | global_attenuator_bypass_cfg_r[asc_pkg::BIT_BYP_V12];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_six_r  <= asc_pkg::RST_CFG_SIX;
         tach_sel_r <= asc_pkg::RST_TACH_SEL;
         cfg_two_r  <= asc_pkg::RST_CFG_TWO;
         global_attenuator_bypass_cfg_r <= asc_pkg::RST_GLOBAL_ATTENUATOR_BYPASS_CFG;
         lock_r     <= '0;
         rd_byte_r  <= 8'h00;
         rd_mem_r   <= 1'b0;
         byp_r      <= 5'h00;
         for (int i = 0; i < NC; i++) begin
            lsb_r[i] <= 2'h0;
         end
      end else begin
         cfg_six_r  <= cfg_six_nxt;
         tach_sel_r <= tach_sel_nxt;
         cfg_two_r  <= cfg_two_nxt;
         global_attenuator_bypass_cfg_r <= global_attenuator_bypass_cfg_nxt;
         lock_r     <= lock_nxt;
         rd_byte_r  <= rd_byte_nxt;
         rd_mem_r   <= rd_mem_nxt;
         byp_r      <= byp_nxt;
         lsb_r      <= lsb_nxt;
      end
   end

   asc_result_mem #(
      .WIDTH (asc_pkg::CODE_W),
      .DEPTH (NC),
      .AW    (asc_pkg::CHAN_W)
   ) u_mem (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (mem_we),
      .wr_addr (chan_r),
      .wr_data (mem_wdata),
      .rd_addr (mem_raddr),
      .rd_data (mem_q)
   );

   // Value registers return the upper eight bits of the 10-bit code
   assign reg_rdata         = rd_mem_r ? mem_q[9:2] : rd_byte_r;
   assign adc_channel       = chan_r;
   assign adc_start         = start_r;
   assign cycle_start       = cstart_r;
   assign atten_bypass      = byp_r;
   assign tach_one_min_high = tach_sel_r;
endmodule

// *** verification/asc_sequencer_asserts.sv ***
// Port-level checker for the ADC sequencer control block
`timescale 1ns/1ps
module asc_sequencer_asserts #(
   parameter int VOLT_CYC = 20
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [9:0] adc_code,
   input wire logic [3:0] adc_channel,
   input wire logic       adc_start,
   input wire logic [4:0] atten_bypass,
   input wire logic [7:0] tach_one_min_high,
   input wire logic       cycle_start
);
   logic [7:0]  cfg2_r, cfg2_nxt, cfg4_r, cfg4_nxt, tach_r, tach_nxt;
   logic [15:0] gap_r, gap_nxt, since_r, since_nxt;
   logic [4:0]  byp_exp;
   // Shadow copies of written registers, cycles since a start or mode write
   always_comb begin
      cfg2_nxt  = (reg_wr && reg_addr == 8'h73) ? reg_wdata : cfg2_r;
      cfg4_nxt  = (reg_wr && reg_addr == 8'h7D) ? reg_wdata : cfg4_r;
      tach_nxt  = (reg_wr && reg_addr == 8'h55) ? reg_wdata : tach_r;
      gap_nxt   = adc_start ? 16'h0001 : gap_r + {15'h0000, ~&gap_r};
      since_nxt = (reg_wr && reg_addr == 8'h73) ? 16'h0000
                : since_r + {15'h0000, ~&since_r};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) {cfg2_r, cfg4_r, tach_r, gap_r, since_r} <= '0;
      else {cfg2_r, cfg4_r, tach_r, gap_r, since_r} <=
         {cfg2_nxt, cfg4_nxt, tach_nxt, gap_nxt, since_nxt};
   end
   assign byp_exp = {cfg4_r[7], cfg4_r[6], 1'b0, cfg4_r[5], cfg4_r[4]}
                  | {5{cfg2_r[5]}};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence exit_single_s;
      reg_wr && reg_addr == 8'h73 && cfg2_r[6] && !reg_wdata[6];
   endsequence
   sequence restart_s;
      ##[1:3] (cycle_start && adc_channel == 4'h0);
   endsequence
   bypass_global_a: assert property (
      reg_wr && reg_addr == 8'h73 && reg_wdata[5]
      |-> ##2 atten_bypass == 5'h1F) else $error("global bypass missing");
   bypass_map_a: assert property (
      atten_bypass == $past(byp_exp)) else $error("bypass map wrong");
   tach_copy_a: assert property (
      reg_wr && reg_addr == 8'h55 |-> ##2 tach_one_min_high ==
      $past(reg_wdata, 2)) else $error("tach limit copy wrong");
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
   unmapped_zero_a: assert property (
      reg_rd && reg_addr == 8'hF0 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   single_chan_a: assert property (
      adc_start && cfg2_r[6] && since_r > 16'h0003
      |-> adc_channel == tach_r[7:4]) else $error("single channel wrong");
   single_period_a: assert property (
      adc_start && cfg2_r[6] && since_r > gap_r + 16'h0003
      |-> gap_r == VOLT_CYC) else $error("single period wrong");
   resume_rr_a: assert property (
      exit_single_s |-> restart_s) else $error("no restart at channel 0");
endmodule
bind asc_sequencer asc_sequencer_asserts #(.VOLT_CYC(VOLT_CYC)) u_chk (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .adc_code(adc_code), .adc_channel(adc_channel), .adc_start(adc_start),
   .atten_bypass(atten_bypass), .tach_one_min_high(tach_one_min_high),
   .cycle_start(cycle_start));

// *** verification/tb_top.sv ***
// Self-checking testbench for the ADC sequencer control block
`timescale 1ns/1ps
module tb_top;
   localparam int VC = 20, RC = 60, LC = 30, CC = 6000, SC = 9000;
   logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic       tog = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [9:0] adc_code = 10'h000;
   logic [7:0] reg_rdata, tach_one_min_high;
   logic [3:0] adc_channel;
   logic [4:0] atten_bypass;
   logic       adc_start, cycle_start;
   int         n_fail = 0, cmp_count = 0;
   always #5 clk = ~clk;
   asc_sequencer #(.VOLT_CYC(VC), .REMOTE_CYC(RC), .LOCAL_CYC(LC),
      .CYCLE_CYC(CC), .SLOW_CYC(SC)) DUT (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .adc_code(adc_code), .adc_channel(adc_channel), .adc_start(adc_start),
      .atten_bypass(atten_bypass), .tach_one_min_high(tach_one_min_high),
      .cycle_start(cycle_start));
   // Swap between full scale and code 1 at each conversion start while tog is set
   always @(posedge clk) begin
      #1;
      if (tog && adc_start === 1'b1) adc_code = adc_code ^ 10'h3FE;
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      tick();
      reg_wr    = 1'b0;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd   = 1'b1;
      tick();
      reg_rd   = 1'b0;
      d        = reg_rdata;
      tick();
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wait_pulse(input bit cyc, output int n);
      n = 0;
      do begin
         tick();
         n++;
      end while ((cyc ? cycle_start : adc_start) !== 1'b1 && n < 20000);
   endtask
   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] ofs [4] = '{8'h10, 8'h55, 8'h73, 8'h7D};
      for (int i = 0; i < 4; i++) begin
         rd(ofs[i], d);
         chk("reset value", 8'h00, d);
         wr(ofs[i], 8'hA5);
         rd(ofs[i], d);
         chk("read back", 8'hA5, d);
      end
      chk("tach copy", 8'hA5, tach_one_min_high);
      rd(8'hF0, d);
      chk("unmapped read", 8'h00, d);
      for (int i = 0; i < 4; i++) wr(ofs[i], 8'h00);
   endtask
   task automatic t_atten();
      logic [4:0] exp [4] = '{5'h01, 5'h02, 5'h08, 5'h10};
      wr(8'h73, 8'h20);
      chk("global bypass", 5'h1F, atten_bypass);
      wr(8'h73, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(8'h7D, 8'h10 << i);
         chk("input bypass", exp[i], atten_bypass);
      end
      wr(8'h7D, 8'h00);
      chk("no bypass", 5'h00, atten_bypass);
   endtask
   task automatic t_single();
      int n;
      for (int c = 0; c < 10; c++) begin
         wr(8'h55, {c[3:0], 4'h6});
         wr(8'h73, 8'h50);
         repeat (2) wait_pulse(1'b0, n);
         chk("single period", VC, n);
         chk("single channel", c[3:0], adc_channel);
         chk("shared select", {c[3:0], 4'h6}, tach_one_min_high);
         wr(8'h73, 8'h00);
         tick(2);
         chk("resume channel", 4'h0, adc_channel);
      end
   endtask
   task automatic t_lock();
      logic [7:0] d;
      int         n;
      wr(8'h55, 8'h30);
      wr(8'h73, 8'h50);
      adc_code = 10'h300;
      repeat (3) wait_pulse(1'b0, n);
      rd(8'h76, d);
      chk("nominal lsbs", 2'b00, d[7:6]);
      rd(8'h23, d);
      chk("nominal code", 8'hC0, d);
      rd(8'h76, d);
      adc_code = 10'h3FF;
      repeat (3) wait_pulse(1'b0, n);
      rd(8'h23, d);
      chk("locked value", 8'hC0, d);
      repeat (3) wait_pulse(1'b0, n);
      rd(8'h76, d);
      chk("full scale lsbs", 2'b11, d[7:6]);
      rd(8'h23, d);
      chk("full scale code", 8'hFF, d);
      wr(8'h73, 8'h00);
   endtask
   task automatic t_timing(input bit averaging_disable);
      logic [7:0] d;
      int         n;
      int         len;
      tog = averaging_disable;
      wr(8'h73, averaging_disable ? 8'h00 : 8'h10);
      rd(8'h20, d);
      repeat (2) wait_pulse(1'b1, n);
      for (int ch = 1; ch < 10; ch++) begin
         len = (ch == 6 || ch == 8) ? RC : (ch == 7) ? LC : VC;
         n = 0;
         while (adc_channel !== ch[3:0] && n < 20000) begin
            tick();
            n++;
         end
         chk("channel dwell", len * (averaging_disable ? 16 : 1), n);
      end
      repeat (2) wait_pulse(1'b1, n);
      chk("cycle time", CC, n);
      if (averaging_disable) begin
         rd(8'h20, d);
         chk("averaged code", 8'h80, d);
         wr(8'h10, 8'h80);
         repeat (3) wait_pulse(1'b1, n);
         chk("slow cycle time", SC, n);
         wr(8'h10, 8'h00);
      end
      tog = 1'b0;
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      tick(12);
      rst_n = 1'b1;
      tick();
      t_regs();
      t_atten();
      t_single();
      t_lock();
      t_timing(1'b0);
      t_timing(1'b1);
      summarize();
   end
   // Run should end near 75000 cycles
   initial begin
      #(95000 * 10);
      n_fail++;
      summarize();
   end
endmodule
